// ### shared/prot_status_consts.svh
// Constants for the protection-status register and its serial commands
`ifndef PROT_STATUS_CONSTS_SVH
`define PROT_STATUS_CONSTS_SVH

// Command opcodes
`define OP_READ_PROT_STATUS 8'h51
`define OP_WRITE_PROT_STATUS 8'h52
`define OP_WRITE_ENABLE 8'h50
`define OP_SCHEME_SELECT 8'h53

// Register bit positions
`define PS_SCHEME_BIT 7
`define PS_ERASE_FAIL_BIT 6
`define PS_PROG_FAIL_BIT 5
`define PS_RSVD_BIT 4
`define PS_ERASE_SUSP_BIT 3
`define PS_PROG_SUSP_BIT 2
`define PS_LOCKDOWN_BIT 1
`define PS_FACTORY_BIT 0

// Power-up values of the one-time bits
`define PS_SCHEME_RST 1'b0
`define PS_LOCKDOWN_RST 1'b0

// Last clock index of one byte per command mode
`define SPI_LAST_UNIT 3'h7
`define QUAD_LAST_UNIT 3'h1

// Controller register word indices (haddr bits 7:2) and fields
`define HC_CMD_OFS 6'h00
`define HC_STATUS_OFS 6'h01
`define HC_QUAD_BIT 8
`define HC_READ_BIT 9
`define HC_BUSY_BIT 0

// Controller serial clock half period in mclk cycles
`define HOST_HALF_CYC 8

`endif

// ### shared/prot_status_pkg.sv
// Types shared by both ends of the protection-status link
package prot_status_pkg;

  typedef enum logic [1:0] {DP_IDLE, DP_OPC, DP_TAIL, DP_READ} dev_phase_e;
  typedef enum logic [2:0] {HP_IDLE, HP_LOW, HP_HIGH, HP_END, HP_GAP} host_phase_e;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic ck_s1;
    logic ck_s2;
    logic ck_d;
    logic [3:0] sio_s1;
    logic [3:0] sio_s2;
    dev_phase_e phase;
    logic quad;
    logic [2:0] unit;
    logic [7:0] opcode;
    logic tail;
    logic [7:0] out_byte;
    logic [3:0] sio_o;
    logic [3:0] sio_oe;
    logic write_enable_latch;
    logic scheme;
    logic lockdown;
    logic factory;
    logic efail;
    logic pfail;
    logic esusp;
    logic psusp;
    logic otp_mode;
  } dev_state_s;

  typedef struct packed {
    logic a_valid;
    logic a_write;
    logic [5:0] a_idx;
    logic [31:0] hrdata;
    host_phase_e phase;
    logic busy;
    logic quad;
    logic rd;
    logic [4:0] unit;
    logic [4:0] last;
    logic [4:0] rd_from;
    logic [7:0] div;
    logic [7:0] tx;
    logic [7:0] rx;
    logic cs_n;
    logic sclk;
    logic [3:0] sio_o;
    logic [3:0] sio_oe;
    logic [3:0] sio_s1;
    logic [3:0] sio_s2;
  } host_state_s;

endpackage

// ### shared/prot_link_if.sv
// Serial link between the flash controller and the protection-status device
`timescale 1ns/100ps
interface prot_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] h_sio_o;
  logic [3:0] h_sio_oe;
  logic [3:0] d_sio_o;
  logic [3:0] d_sio_oe;
  logic [3:0] sio;

  // Undriven lines float to one, as with a pull-up
  assign sio = (h_sio_oe & h_sio_o) | (d_sio_oe & d_sio_o) | ~(h_sio_oe | d_sio_oe);

  modport host (output cs_n, output sclk, output h_sio_o, output h_sio_oe, input sio);
  modport dev (input cs_n, input sclk, input sio, output d_sio_o, output d_sio_oe);
endinterface

// ### hw/prot_status_dev.sv
// Device end: protection-status register and its serial command decoder
//
// Behaviour
// - Status read works anytime, repeats while clocked
// - Read: select, opcode, register byte out, deselect
// - Opcode takes eight single or two quad clocks
// - Upper data lines ignored in single-line mode
// - Write command needs write enable latch set
// - Write command only sets lockdown bit one
// - Lockdown set freezes first OTP area, itself
// - Write rejected unless deselect on byte boundary
// - Erase fail sets bit six, success clears
// - Program fail sets bit five, success clears
// - Fail flags only report, never halt operations
// - Erase suspend sets bit three, resume clears
// - Program suspend sets bit two, resume clears
// - Bit zero shows factory lock of second area
// - Secured OTP mode denies main array access
// - Fail, suspend flags volatile, zero at power-up
// - Bit seven picks block-lock or per-sector scheme
// - Scheme command sets selector, needs write enable
// - Selector never returns to zero once set
// - Per-sector scheme disables the block-lock bits
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "prot_status_consts.svh"

module prot_status_dev (
  input wire logic mclk_i, // System clock
  input wire logic rst_i, // Synchronous reset, models power-up
  prot_link_if.dev link, // Serial link to the controller
  input wire logic quad_mode_i, // Quad command mode active
  input wire logic factory_lock_i, // Factory lock strap of second OTP area
  input wire logic otp_mode_i, // Device is in secured OTP mode
  input wire logic erase_fail_i, // Pulse: erase failed or hit protected region
  input wire logic erase_pass_i, // Pulse: erase succeeded
  input wire logic prog_fail_i, // Pulse: program failed or hit protected region
  input wire logic prog_pass_i, // Pulse: program succeeded
  input wire logic erase_suspend_i, // Pulse: erase suspend took effect
  input wire logic erase_resume_i, // Pulse: erase resumed
  input wire logic prog_suspend_i, // Pulse: program suspend took effect
  input wire logic prog_resume_i, // Pulse: program resumed
  output logic [7:0] status_o, // Current register value
  output logic wel_o, // Write enable latch
  output logic block_lock_enable_o, // Block-lock bits take effect
  output logic otp1_write_allow_o, // First OTP area may be updated
  output logic main_array_allow_o // Main array may be accessed
);

  // ****************************************************************
  // State
  // ****************************************************************
  prot_status_pkg::dev_state_s s_r;
  prot_status_pkg::dev_state_s s_nxt;
  logic rise;
  logic fall;
  logic [2:0] last_unit;
  logic [7:0] op_nxt;
  logic [7:0] cur_status;

  function automatic logic [7:0] pack_status(input prot_status_pkg::dev_state_s st);
    logic [7:0] v;
    v = 8'h00;
    v[`PS_SCHEME_BIT] = st.scheme;
    v[`PS_ERASE_FAIL_BIT] = st.efail;
    v[`PS_PROG_FAIL_BIT] = st.pfail;
    v[`PS_RSVD_BIT] = 1'b0;
    v[`PS_ERASE_SUSP_BIT] = st.esusp;
    v[`PS_PROG_SUSP_BIT] = st.psusp;
    v[`PS_LOCKDOWN_BIT] = st.lockdown;
    v[`PS_FACTORY_BIT] = st.factory;
    return v;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_nxt = s_r;
    // Link inputs cross through two flops before use
    s_nxt.cs_s1 = link.cs_n;
    s_nxt.cs_s2 = s_r.cs_s1;
    s_nxt.ck_s1 = link.sclk;
    s_nxt.ck_s2 = s_r.ck_s1;
    s_nxt.ck_d = s_r.ck_s2;
    s_nxt.sio_s1 = link.sio;
    s_nxt.sio_s2 = s_r.sio_s1;
    rise = s_r.ck_s2 & ~s_r.ck_d;
    fall = ~s_r.ck_s2 & s_r.ck_d;
    cur_status = pack_status(s_r);
    last_unit = s_r.quad ? `QUAD_LAST_UNIT : `SPI_LAST_UNIT;
    if (s_r.quad)
    begin
      op_nxt = {s_r.opcode[3:0], s_r.sio_s2};
    end
    else
    begin
      op_nxt = {s_r.opcode[6:0], s_r.sio_s2[0]};
    end

    // Memory events; set wins over a clear in the same cycle
    s_nxt.factory = factory_lock_i;
    s_nxt.otp_mode = otp_mode_i;
    if (erase_fail_i)
      s_nxt.efail = 1'b1;
    else if (erase_pass_i)
      s_nxt.efail = 1'b0;
    if (prog_fail_i)
      s_nxt.pfail = 1'b1;
    else if (prog_pass_i)
      s_nxt.pfail = 1'b0;
    if (erase_suspend_i)
      s_nxt.esusp = 1'b1;
    else if (erase_resume_i)
      s_nxt.esusp = 1'b0;
    if (prog_suspend_i)
      s_nxt.psusp = 1'b1;
    else if (prog_resume_i)
      s_nxt.psusp = 1'b0;

    // ****************************************************************
    // Command frame
    // ****************************************************************
    if (s_r.cs_s2)
    begin
      // Deselect: execute only on an exact byte boundary
      if (s_r.phase == prot_status_pkg::DP_TAIL && !s_r.tail)
      begin
        unique case (s_r.opcode)
          `OP_WRITE_ENABLE:
          begin
            s_nxt.write_enable_latch = 1'b1;
          end
          `OP_WRITE_PROT_STATUS:
          begin
            // Once locked nothing changes, WRITE_ENABLE_LATCH is kept
            if (s_r.write_enable_latch && !s_r.lockdown)
            begin
              s_nxt.lockdown = 1'b1;
              s_nxt.write_enable_latch = 1'b0;
            end
          end
          `OP_SCHEME_SELECT:
          begin
            if (s_r.write_enable_latch)
            begin
              s_nxt.scheme = 1'b1;
              s_nxt.write_enable_latch = 1'b0;
            end
          end
          default:
          begin
          end
        endcase
      end
      s_nxt.phase = prot_status_pkg::DP_IDLE;
      s_nxt.sio_oe = 4'h0;
      s_nxt.sio_o = 4'h0;
    end
    else if (s_r.phase == prot_status_pkg::DP_IDLE)
    begin
      s_nxt.phase = prot_status_pkg::DP_OPC;
      s_nxt.quad = quad_mode_i;
      s_nxt.unit = 3'h0;
      s_nxt.tail = 1'b0;
    end
    else
    begin
      unique case (s_r.phase)
        prot_status_pkg::DP_OPC:
        begin
          if (rise)
          begin
            s_nxt.opcode = op_nxt;
            s_nxt.unit = s_r.unit + 3'h1;
            if (s_r.unit == last_unit)
            begin
              if (op_nxt == `OP_READ_PROT_STATUS)
              begin
                s_nxt.phase = prot_status_pkg::DP_READ;
                s_nxt.out_byte = cur_status;
              end
              else
              begin
                s_nxt.phase = prot_status_pkg::DP_TAIL;
              end
              s_nxt.unit = 3'h0;
            end
          end
        end
        prot_status_pkg::DP_TAIL:
        begin
          // Any clock past the opcode spoils the byte boundary
          if (rise)
            s_nxt.tail = 1'b1;
        end
        prot_status_pkg::DP_READ:
        begin
          // Data changes on the falling edge, MSB first, byte repeats
          if (fall)
          begin
            s_nxt.unit = s_r.unit + 3'h1;
            if (s_r.quad)
            begin
              s_nxt.sio_o = s_r.out_byte[7:4];
              s_nxt.sio_oe = 4'hf;
              s_nxt.out_byte = {s_r.out_byte[3:0], 4'h0};
            end
            else
            begin
              s_nxt.sio_o = {2'b00, s_r.out_byte[7], 1'b0};
              s_nxt.sio_oe = 4'h2;
              s_nxt.out_byte = {s_r.out_byte[6:0], 1'b0};
            end
            if (s_r.unit == last_unit)
            begin
              // Fresh snapshot per byte so live flags show
              s_nxt.out_byte = cur_status;
              s_nxt.unit = 3'h0;
            end
          end
        end
        default:
        begin
        end
      endcase
    end

    if (rst_i)
    begin
      s_nxt = '0;
      s_nxt.cs_s1 = 1'b1;
      s_nxt.cs_s2 = 1'b1;
      s_nxt.phase = prot_status_pkg::DP_IDLE;
      s_nxt.scheme = `PS_SCHEME_RST;
      s_nxt.lockdown = `PS_LOCKDOWN_RST;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    s_r <= s_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Fail flags feed no control path, so nothing is stalled
  assign status_o = pack_status(s_r);
  assign wel_o = s_r.write_enable_latch;
  assign block_lock_enable_o = ~s_r.scheme;
  assign otp1_write_allow_o = ~s_r.lockdown;
  assign main_array_allow_o = ~s_r.otp_mode;
  assign link.d_sio_o = s_r.sio_o;
  assign link.d_sio_oe = s_r.sio_oe;

endmodule

// ### hw/prot_status_host.sv
// Controller end: AHB-Lite programmed serial command issuer
`timescale 1ns/100ps
`include "prot_status_consts.svh"

module prot_status_host #(
  parameter int HALF_CYC = `HOST_HALF_CYC
) (
  input wire logic mclk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic hsel_i, // AHB slave select
  input wire logic [31:0] haddr_i, // AHB address
  input wire logic [1:0] htrans_i, // AHB transfer type
  input wire logic hwrite_i, // AHB write
  input wire logic [2:0] hsize_i, // AHB size, word only
  input wire logic [31:0] hwdata_i, // AHB write data
  input wire logic hready_i, // AHB bus ready
  output logic hreadyout_o, // AHB slave ready
  output logic hresp_o, // AHB response, always OKAY
  output logic [31:0] hrdata_o, // AHB read data
  prot_link_if.host link // Serial link to the device
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam logic [7:0] HALF_END = 8'(HALF_CYC - 1);
  prot_status_pkg::host_state_s s_r;
  prot_status_pkg::host_state_s s_nxt;
  logic [4:0] ub;

  // Put the next unit of the shift register on the lines
  function automatic prot_status_pkg::host_state_s drive(
    input prot_status_pkg::host_state_s st, input logic [4:0] unit);
    prot_status_pkg::host_state_s r;
    r = st;
    if (st.quad)
    begin
      r.sio_o = st.tx[7:4];
      r.sio_oe = 4'hf;
      r.tx = {st.tx[3:0], 4'h0};
    end
    else
    begin
      r.sio_o = {3'b000, st.tx[7]};
      r.sio_oe = 4'h1;
      r.tx = {st.tx[6:0], 1'b0};
    end
    // Release the lines while the device answers
    if (st.rd && unit >= st.rd_from)
      r.sio_oe = 4'h0;
    return r;
  endfunction

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sio_s1 = link.sio;
    s_nxt.sio_s2 = s_r.sio_s1;
    ub = hwdata_i[`HC_QUAD_BIT] ? 5'h2 : 5'h8;

    // ****************************************************************
    // AHB-Lite slave, zero wait states
    // ****************************************************************
    if (s_r.a_valid && s_r.a_write && s_r.a_idx == `HC_CMD_OFS && !s_r.busy)
    begin
      s_nxt.busy = 1'b1;
      s_nxt.quad = hwdata_i[`HC_QUAD_BIT];
      s_nxt.rd = hwdata_i[`HC_READ_BIT];
      s_nxt.tx = hwdata_i[7:0];
      s_nxt.rd_from = ub + 5'(hwdata_i[11:10]);
      s_nxt.last = ub + 5'(hwdata_i[11:10]) - 5'h1;
      if (hwdata_i[`HC_READ_BIT])
        s_nxt.last = ub + 5'(hwdata_i[11:10]) + ub - 5'h1;
      s_nxt.unit = 5'h0;
      s_nxt.div = 8'h00;
      s_nxt.cs_n = 1'b0;
      s_nxt.phase = prot_status_pkg::HP_LOW;
      s_nxt = drive(s_nxt, 5'h0);
    end
    s_nxt.a_valid = hsel_i && htrans_i[1] && hready_i;
    s_nxt.a_write = hwrite_i;
    s_nxt.a_idx = haddr_i[7:2];
    s_nxt.hrdata = 32'h0000_0000;
    if (hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i[7:2] == `HC_STATUS_OFS)
      s_nxt.hrdata = {16'h0000, s_r.rx, 7'h00, s_r.busy};

    // ****************************************************************
    // Serial engine, mode 0, clock idles low
    // ****************************************************************
    if (s_r.phase != prot_status_pkg::HP_IDLE)
      s_nxt.div = s_r.div + 8'h01;
    if (s_r.div == HALF_END)
    begin
      s_nxt.div = 8'h00;
      unique case (s_r.phase)
        prot_status_pkg::HP_LOW:
        begin
          // Sample late in the low half, after the device has settled
          if (s_r.rd && s_r.unit >= s_r.rd_from)
            s_nxt.rx = s_r.quad ? {s_r.rx[3:0], s_r.sio_s2} : {s_r.rx[6:0], s_r.sio_s2[1]};
          s_nxt.sclk = 1'b1;
          s_nxt.phase = prot_status_pkg::HP_HIGH;
        end
        prot_status_pkg::HP_HIGH:
        begin
          s_nxt.sclk = 1'b0;
          s_nxt.unit = s_r.unit + 5'h1;
          if (s_r.unit == s_r.last)
            s_nxt.phase = prot_status_pkg::HP_END;
          else
          begin
            s_nxt.phase = prot_status_pkg::HP_LOW;
            s_nxt = drive(s_nxt, s_r.unit + 5'h1);
          end
        end
        prot_status_pkg::HP_END:
        begin
          s_nxt.cs_n = 1'b1;
          s_nxt.sio_oe = 4'h0;
          s_nxt.phase = prot_status_pkg::HP_GAP;
        end
        prot_status_pkg::HP_GAP:
        begin
          s_nxt.busy = 1'b0;
          s_nxt.phase = prot_status_pkg::HP_IDLE;
        end
        default:
        begin
        end
      endcase
    end

    if (rst_i)
    begin
      s_nxt = '0;
      s_nxt.cs_n = 1'b1;
      s_nxt.phase = prot_status_pkg::HP_IDLE;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    s_r <= s_nxt;
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = s_r.hrdata;
  assign link.cs_n = s_r.cs_n;
  assign link.sclk = s_r.sclk;
  assign link.h_sio_o = s_r.sio_o;
  assign link.h_sio_oe = s_r.sio_oe;

endmodule

// ### dv/prot_status_properties.sv
// Concurrent checks on the serial link between controller and device
`timescale 1ns/100ps
module prot_status_properties (
  input wire logic mclk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic cs_n, // Chip select, active low
  input wire logic sclk, // Serial clock
  input wire logic [3:0] h_sio_o, // Controller data
  input wire logic [3:0] h_sio_oe, // Controller enables
  input wire logic [3:0] d_sio_o, // Device data
  input wire logic [3:0] d_sio_oe, // Device enables
  input wire logic [3:0] sio // Resolved line levels
);
  // ****************************************
  // Link timing and line ownership
  // ****************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // Half periods assume the controller's default half period of 8 cycles
  sequence s_low_half;
    (!sclk)[*7];
  endsequence
  sequence s_high_half;
    sclk[*8];
  endsequence

  property p_idle_clock_low;
    cs_n |-> !sclk;
  endproperty
  a_idle_clock_low: assert property (p_idle_clock_low)
    else $error("Serial clock high while deselected");
  property p_first_unit;
    $fell(cs_n) |-> s_low_half ##[1:2] sclk;
  endproperty
  a_first_unit: assert property (p_first_unit)
    else $error("First serial clock edge mistimed after select");
  property p_high_time;
    $rose(sclk) |-> s_high_half ##1 !sclk;
  endproperty
  a_high_time: assert property (p_high_time)
    else $error("Serial clock high time wrong");
  property p_low_time;
    $fell(sclk) && !cs_n |-> s_low_half ##1 !sclk;
  endproperty
  a_low_time: assert property (p_low_time)
    else $error("Serial clock low time too short");
  // The device samples while the clock is high, so nothing may move then
  property p_wire_stable;
    sclk && $past(sclk) |-> $stable(sio) && $stable(h_sio_o & h_sio_oe)
      && $stable(d_sio_o & d_sio_oe);
  endproperty
  a_wire_stable: assert property (p_wire_stable)
    else $error("Data line changed while serial clock high");
  property p_dev_release;
    $rose(cs_n) |-> ##[1:6] (d_sio_oe == 4'h0);
  endproperty
  a_dev_release: assert property (p_dev_release)
    else $error("Device still drives after deselect");
  property p_no_contention;
    (h_sio_oe & d_sio_oe) == 4'h0;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("Both ends drive one data line");
  // The device sees deselect through its synchroniser, so it lets go up to 3 cycles late
  property p_dev_lines;
    d_sio_oe != 4'h0 |-> (!cs_n || !$past(cs_n, 3)) && (d_sio_oe == 4'h2 || d_sio_oe == 4'hf);
  endproperty
  a_dev_lines: assert property (p_dev_lines)
    else $error("Device drives an unexpected set of lines");
  property p_cs_gap;
    $rose(cs_n) |-> cs_n[*4];
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("Deselect gap shorter than four cycles");
endmodule

// ### dv/flash_security_status_register_test.sv
// Testbench driving the controller over AHB-Lite against the device end
`timescale 1ns/100ps
`include "prot_status_consts.svh"
module flash_security_status_register_test;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp;
  logic [31:0] hrdata;
  logic quad = 1'b0;
  logic strap = 1'b1;
  logic otp = 1'b0;
  logic [7:0] ev = 8'h0;
  logic [7:0] status;
  logic write_enable_latch, blk_en, otp1_ok, main_ok;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;

  always #50 mclk_i = ~mclk_i;

  prot_link_if prot_link_if_i ();
  prot_status_host prot_status_host_i (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .link(prot_link_if_i.host));
  prot_status_dev prot_status_dev_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(prot_link_if_i.dev),
    .quad_mode_i(quad), .factory_lock_i(strap), .otp_mode_i(otp), .erase_fail_i(ev[0]),
    .erase_pass_i(ev[1]), .prog_fail_i(ev[2]), .prog_pass_i(ev[3]), .erase_suspend_i(ev[4]),
    .erase_resume_i(ev[5]), .prog_suspend_i(ev[6]), .prog_resume_i(ev[7]), .status_o(status),
    .wel_o(write_enable_latch), .block_lock_enable_o(blk_en), .otp1_write_allow_o(otp1_ok),
    .main_array_allow_o(main_ok));
  prot_status_properties prot_status_properties_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .cs_n(prot_link_if_i.cs_n), .sclk(prot_link_if_i.sclk), .h_sio_o(prot_link_if_i.h_sio_o),
    .h_sio_oe(prot_link_if_i.h_sio_oe), .d_sio_o(prot_link_if_i.d_sio_o),
    .d_sio_oe(prot_link_if_i.d_sio_oe), .sio(prot_link_if_i.sio));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic wrap_up;
    $display("Checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_flag(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    @(posedge mclk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= addr;
    hwrite <= wr;
    do @(posedge mclk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge mclk_i); while (hready !== 1'b1);
    rdata = hrdata;
    chk_flag("hresp", 1'b0, hresp);
  endtask

  // Waits on the busy flag; only the global timeout ends a hung command
  task automatic cmd(input logic [7:0] op, input logic qd, input logic rd,
                     input logic [1:0] extra, output logic [7:0] rbyte);
    logic [31:0] w;
    quad <= qd;
    ahb(1'b1, 32'h0, {20'h0, extra, rd, qd, op}, w);
    do ahb(1'b0, 32'h4, 32'h0, w); while (w[0] !== 1'b0);
    rbyte = w[15:8];
  endtask

  task automatic rd_status(input logic qd, input logic [7:0] exp);
    logic [7:0] b;
    cmd(`OP_READ_PROT_STATUS, qd, 1'b1, 2'h0, b);
    chk_word("read byte", {24'h0, exp}, {24'h0, b});
    chk_word("status_o", {24'h0, exp}, {24'h0, status});
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge mclk_i);
    ev <= m;
    @(posedge mclk_i);
    ev <= 8'h0;
  endtask

  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      wrap_up;
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    logic [31:0] w;
    logic [7:0] b;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk_flag("blk_en", 1'b1, blk_en);
    chk_flag("otp1_ok", 1'b1, otp1_ok);
    chk_flag("main_ok", 1'b1, main_ok);
    rd_status(1'b0, 8'h01);
    ahb(1'b0, 32'h10, 32'h0, w);
    chk_word("unmapped", 32'h0, w);
    // Fail and suspend events, read once per command mode
    pulse(8'h55);
    rd_status(1'b0, 8'h6d);
    rd_status(1'b1, 8'h6d);
    pulse(8'haa);
    rd_status(1'b0, 8'h01);
    strap <= 1'b0;
    rd_status(1'b0, 8'h00);
    cmd(`OP_WRITE_PROT_STATUS, 1'b0, 1'b0, 2'h0, b);
    rd_status(1'b0, 8'h00);
    cmd(`OP_WRITE_ENABLE, 1'b0, 1'b0, 2'h0, b);
    chk_flag("wel", 1'b1, write_enable_latch);
    // A clock beyond the opcode byte must void the write
    cmd(`OP_WRITE_PROT_STATUS, 1'b0, 1'b0, 2'h1, b);
    rd_status(1'b0, 8'h00);
    chk_flag("wel", 1'b1, write_enable_latch);
    cmd(`OP_WRITE_PROT_STATUS, 1'b1, 1'b0, 2'h0, b);
    rd_status(1'b1, 8'h02);
    chk_flag("wel", 1'b0, write_enable_latch);
    chk_flag("otp1_ok", 1'b0, otp1_ok);
    cmd(`OP_SCHEME_SELECT, 1'b0, 1'b0, 2'h0, b);
    rd_status(1'b0, 8'h02);
    cmd(`OP_WRITE_ENABLE, 1'b1, 1'b0, 2'h0, b);
    cmd(`OP_SCHEME_SELECT, 1'b1, 1'b0, 2'h0, b);
    rd_status(1'b0, 8'h82);
    chk_flag("blk_en", 1'b0, blk_en);
    cmd(`OP_WRITE_ENABLE, 1'b0, 1'b0, 2'h0, b);
    cmd(`OP_WRITE_PROT_STATUS, 1'b0, 1'b0, 2'h0, b);
    rd_status(1'b0, 8'h82);
    chk_flag("wel", 1'b1, write_enable_latch);
    otp <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk_flag("main_ok", 1'b0, main_ok);
    wrap_up;
  end
endmodule
